// File: logic/scr_regs.vh
// Register addresses, field positions, codes and timing of the control bank
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// ==========================================================================
// Register addresses and power-up values
`define SCR_ADDR_HI        2
`define SCR_ADDR_LO        0
`define SCR_ADDR_REG0      3'h0
`define SCR_ADDR_REG1      3'h1
`define SCR_ADDR_REG2      3'h2
`define SCR_ADDR_REG3      3'h3
`define SCR_ADDR_REG5      3'h5
`define SCR_ADDR_READBACK  3'h6
`define SCR_NUM_REGS       6
`define SCR_RST_REG0       32'h007D0000
`define SCR_RST_REG1       32'h2000FFF9
`define SCR_RST_REG2       32'h00004042
`define SCR_RST_REG3       32'h0000000B
`define SCR_RST_REG4       32'h6180B23C
`define SCR_RST_REG5       32'h00400005
`define SCR_RST_N_FIELD    16'h00FA
`define SCR_RST_MOD_FIELD  12'hFFF
`define SCR_RST_RDIV_FIELD 10'h001
`define SCR_RST_CP_FIELD   4'h0

// ==========================================================================
// Field positions
`define SCR_INT_BIT        31
`define SCR_N_HI           30
`define SCR_N_LO           15
`define SCR_FRAC_HI        14
`define SCR_FRAC_LO        3
`define SCR_LIN_HI         30
`define SCR_LIN_LO         29
`define SCR_PTEST_HI       28
`define SCR_PTEST_LO       27
`define SCR_PHASE_HI       26
`define SCR_PHASE_LO       15
`define SCR_MOD_HI         14
`define SCR_MOD_LO         3
`define SCR_NOISE_HI       30
`define SCR_NOISE_LO       29
`define SCR_MUXL_HI        28
`define SCR_MUXL_LO        26
`define SCR_RDIV_HI        23
`define SCR_RDIV_LO        14
`define SCR_CP_HI          12
`define SCR_CP_LO          9
`define SCR_OSC_HI         31
`define SCR_OSC_LO         26
`define SCR_VAS_DIS_BIT    25
`define SCR_AUTOSELECT_TEMP_COMP_BIT   24
`define SCR_CDM_HI         16
`define SCR_CDM_LO         15
`define SCR_CLOCK_DIVIDER_VALUE_HI        14
`define SCR_CLOCK_DIVIDER_VALUE_LO        3
`define SCR_BSH_HI         25
`define SCR_BSH_LO         24
`define SCR_BSL_HI         19
`define SCR_BSL_LO         12
`define SCR_MUXH_BIT       18
`define SCR_F01_BIT        24
`define SCR_CONVERTER_START_BIT       6
`define SCR_CONVERTER_SOURCE_SELECT_HI        5
`define SCR_CONVERTER_SOURCE_SELECT_LO        3

// ==========================================================================
// Codes
`define SCR_SRC_TUNE       3'h4
`define SCR_SRC_TEMP       3'h1
`define SCR_CDM_PHASE      2'h2
`define SCR_NOISE_LOW      2'h0
`define SCR_NOISE_RSVD     2'h1
`define SCR_MUX_HIZ        4'h0
`define SCR_MUX_HIGH       4'h1
`define SCR_MUX_LOW        4'h2
`define SCR_MUX_DLOCK      4'h6
`define SCR_MUX_SYNC       4'h7
`define SCR_MUX_READ       4'hC
`define SCR_INT_N_MIN      16'h0010
`define SCR_FRAC_N_MIN     16'h0013
`define SCR_FRAC_N_MAX     16'h0FFB
`define SCR_MOD_MIN        12'h002
`define SCR_OSC_FIRST      6'h20
`define SCR_OSC_BITS       4'h6
`define SCR_VAS_STEPS      4'hA
`define SCR_ADC_STEPS      3'h7

// ==========================================================================
// Timing
`define SCR_SYS_CLK_MHZ    125
`define SCR_CONV_TIME_US   100
`define SCR_TEMP_TIME_MS   100

`endif

// File: logic/scr_tick_div.v
// Programmable divider giving one tick every divisor clocks while enabled
`timescale 1ns/1ps
module scr_tick_div #(
    parameter WIDTH = 12
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             enable,
    input  wire [WIDTH-1:0] divisor,
    output reg              tick
);
    reg [WIDTH-1:0] count;

    // Restarts on enable so the first tick lands one full period later
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
            tick  <= 1'b0;
        end else if (!enable) begin
            count <= {WIDTH{1'b0}};
            tick  <= 1'b0;
        end else if (count + 1'b1 >= divisor) begin
            count <= {WIDTH{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule // scr_tick_div

// File: logic/scr_control_bank.v
// Serial-programmed control bank with converter and autoselect sequencing
`timescale 1ns/1ps
`include "scr_regs.vh"

//Contract
// - 7-bit result readable at readback bits 22:16
// - Source code 100 selects tuning voltage
// - Source code 001 selects temperature sensor
// - Start bit begins conversion, done within 100 us
// - Register 0 write starts autoselect unless disabled
// - Autoselect disabled uses manual 6-bit oscillator field
// - Autoselect finishes in ten band-select clocks
// - Temperature compensation stretches acquisition to 100 ms
// - After lock, phase steps by programmed phase value
// - Sync mode: pin rising edge resets counters
// - Modulator offers low-noise and two dithering modes
// - Register contents kept in low power
// - Register 0 holds mode, integer and fraction
// - Bits 2:0 of each word address the register
// - Register 1 holds pump linearity and test mode
// - Modulus 2..4095, applied on next register 0 write
module scr_control_bank #(
    parameter CONV_CYCLES = `SCR_CONV_TIME_US * `SCR_SYS_CLK_MHZ,
    parameter TEMP_CYCLES = `SCR_TEMP_TIME_MS * `SCR_SYS_CLK_MHZ * 1000
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        ser_clk,
    input  wire        ser_data,
    input  wire        ser_le,
    input  wire        mux_in,
    output reg         mux_out,
    output reg         mux_oe,
    input  wire        tune_above_mid,
    input  wire [6:0]  tune_level,
    input  wire [6:0]  temp_level,
    output reg         integer_mode,
    output reg  [15:0] int_value,
    output reg  [11:0] frac_value,
    output reg  [11:0] modulus,
    output reg  [9:0]  ref_div,
    output reg  [3:0]  pump_current,
    output reg  [1:0]  pump_linearity,
    output reg  [1:0]  pump_test_mode,
    output reg  [1:0]  noise_mode,
    output reg  [5:0]  osc_select,
    output reg         autoselect_busy,
    output reg         phase_step,
    output reg  [11:0] phase_step_value,
    output reg         sync_reset,
    output reg         range_error
);
    localparam VAS_IDLE   = 2'h0;
    localparam VAS_SEARCH = 2'h1;
    localparam VAS_SETTLE = 2'h2;
    localparam [13:0] CONV_LIMIT = CONV_CYCLES[13:0];
    localparam [23:0] TEMP_LIMIT = TEMP_CYCLES[23:0];

    // 4-bit multipurpose pin function, split across two registers
    function [3:0] pin_function;
        input [31:0] r2;
        input [31:0] r5;
        begin
            pin_function = {r5[`SCR_MUXH_BIT], r2[`SCR_MUXL_HI:`SCR_MUXL_LO]};
        end
    endfunction

    // ======================================================================
    // Pin synchronisers
    // Level codes may tear across bits; converter samples them once, at the end of conversion
    reg  [18:0] pin_s1;
    reg  [18:0] pin_s2;
    reg  [18:0] pin_d;
    wire [18:0] pin_raw = {tune_above_mid, temp_level, tune_level,
                           mux_in, ser_le, ser_data, ser_clk};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 19'h00000;
            pin_s2 <= 19'h00000;
            pin_d  <= 19'h00000;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    wire       sclk_rise = pin_s2[0] & ~pin_d[0];
    wire       le_rise   = pin_s2[2] & ~pin_d[2];
    wire       mux_rise  = pin_s2[3] & ~pin_d[3];
    wire [6:0] tune_s    = pin_s2[10:4];
    wire [6:0] temp_s    = pin_s2[17:11];
    wire       above_s   = pin_s2[18];

    // ======================================================================
    // Serial shift and register store
    reg  [31:0] shift_in;
    reg  [31:0] regs [0:`SCR_NUM_REGS-1];
    wire [2:0]  waddr  = shift_in[`SCR_ADDR_HI:`SCR_ADDR_LO];
    wire        wr_any = le_rise && (waddr < `SCR_ADDR_READBACK);
    wire        wr0    = le_rise && (waddr == `SCR_ADDR_REG0);
    wire        wr3    = le_rise && (waddr == `SCR_ADDR_REG3);
    wire        wr5    = le_rise && (waddr == `SCR_ADDR_REG5);
    wire [3:0]  pin_fn = pin_function(regs[2], regs[5]);

    // Contents only change on writes, so low power keeps them
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_in <= 32'h00000000;
            regs[0]  <= `SCR_RST_REG0;
            regs[1]  <= `SCR_RST_REG1;
            regs[2]  <= `SCR_RST_REG2;
            regs[3]  <= `SCR_RST_REG3;
            regs[4]  <= `SCR_RST_REG4;
            regs[5]  <= `SCR_RST_REG5;
        end else begin
            if (sclk_rise)
                shift_in <= {shift_in[30:0], pin_s2[1]};
            if (wr_any)
                regs[waddr] <= shift_in;
        end
    end

    // ======================================================================
    // Active fields; buffered ones move only on a register 0 write
    wire [15:0] new_n   = shift_in[`SCR_N_HI:`SCR_N_LO];
    wire [11:0] new_f   = shift_in[`SCR_FRAC_HI:`SCR_FRAC_LO];
    wire        new_int = shift_in[`SCR_INT_BIT];
    wire [11:0] sh_mod  = regs[1][`SCR_MOD_HI:`SCR_MOD_LO];
    wire        auto_whole = regs[5][`SCR_F01_BIT] && (new_f == 12'h000);
    wire        int_eff = new_int | auto_whole;
    wire [1:0]  noise_f = regs[2][`SCR_NOISE_HI:`SCR_NOISE_LO];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            integer_mode   <= 1'b0;
            int_value      <= `SCR_RST_N_FIELD;
            frac_value     <= 12'h000;
            modulus        <= `SCR_RST_MOD_FIELD;
            ref_div        <= `SCR_RST_RDIV_FIELD;
            pump_current   <= `SCR_RST_CP_FIELD;
            range_error    <= 1'b0;
            pump_linearity <= 2'h0;
            pump_test_mode <= 2'h0;
            noise_mode     <= 2'h0;
        end else begin
            if (wr0) begin
                integer_mode <= int_eff;
                int_value    <= new_n;
                frac_value   <= new_f;
                modulus      <= sh_mod;
                ref_div      <= regs[2][`SCR_RDIV_HI:`SCR_RDIV_LO];
                pump_current <= regs[2][`SCR_CP_HI:`SCR_CP_LO];
                // Out-of-range values are flagged, not corrected
                range_error  <= (sh_mod < `SCR_MOD_MIN) ||
                    (new_int ? (new_n < `SCR_INT_N_MIN) :
                     (new_n < `SCR_FRAC_N_MIN || new_n > `SCR_FRAC_N_MAX));
            end
            pump_linearity <= regs[1][`SCR_LIN_HI:`SCR_LIN_LO];
            pump_test_mode <= regs[1][`SCR_PTEST_HI:`SCR_PTEST_LO];
            // Reserved code falls back to low-noise
            noise_mode <= (noise_f == `SCR_NOISE_RSVD) ?
                          `SCR_NOISE_LOW : noise_f;
        end
    end

    // ======================================================================
    // Oscillator autoselect
    reg  [1:0]  vas_state;
    reg  [3:0]  vas_step;
    reg  [5:0]  vas_mask;
    reg  [23:0] settle_cnt;
    reg         locked;
    wire        bs_tick;
    wire        vas_dis  = regs[3][`SCR_VAS_DIS_BIT];
    wire        autoselect_temp_comp = regs[3][`SCR_AUTOSELECT_TEMP_COMP_BIT];
    wire [9:0]  bs_div   = {regs[4][`SCR_BSH_HI:`SCR_BSH_LO],
                            regs[4][`SCR_BSL_HI:`SCR_BSL_LO]};

    scr_tick_div #(.WIDTH(10)) u_bs_div (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .enable  (vas_state == VAS_SEARCH),
        .divisor (bs_div),
        .tick    (bs_tick)
    );

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vas_state       <= VAS_IDLE;
            vas_step        <= 4'h0;
            vas_mask        <= 6'h00;
            settle_cnt      <= 24'h000000;
            osc_select      <= 6'h00;
            locked          <= 1'b0;
            autoselect_busy <= 1'b0;
        end else begin
            if (wr0 && !vas_dis) begin
                vas_state       <= VAS_SEARCH;
                vas_step        <= 4'h0;
                vas_mask        <= `SCR_OSC_FIRST;
                osc_select      <= `SCR_OSC_FIRST;
                locked          <= 1'b0;
                autoselect_busy <= 1'b1;
            end else if (vas_dis) begin
                vas_state       <= VAS_IDLE;
                osc_select      <= regs[3][`SCR_OSC_HI:`SCR_OSC_LO];
                locked          <= 1'b1;
                autoselect_busy <= 1'b0;
            end else begin
                case (vas_state)
                    VAS_SEARCH: begin
                        if (bs_tick) begin
                            vas_step <= vas_step + 1'b1;
                            // Binary search over core and sub-band bits
                            if (vas_step < `SCR_OSC_BITS) begin
                                osc_select <= (above_s ? osc_select :
                                    (osc_select & ~vas_mask)) |
                                    (vas_mask >> 1);
                                vas_mask <= vas_mask >> 1;
                            end
                            if (vas_step == `SCR_VAS_STEPS - 1'b1) begin
                                settle_cnt <= 24'h000000;
                                if (autoselect_temp_comp) begin
                                    vas_state <= VAS_SETTLE;
                                end else begin
                                    vas_state       <= VAS_IDLE;
                                    locked          <= 1'b1;
                                    autoselect_busy <= 1'b0;
                                end
                            end
                        end
                    end
                    VAS_SETTLE: begin
                        settle_cnt <= settle_cnt + 1'b1;
                        if (settle_cnt >= TEMP_LIMIT - 1'b1) begin
                            vas_state       <= VAS_IDLE;
                            locked          <= 1'b1;
                            autoselect_busy <= 1'b0;
                        end
                    end
                    default: begin
                        vas_state <= VAS_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Phase step and multi-device sync
    wire [1:0] old_cdm = regs[3][`SCR_CDM_HI:`SCR_CDM_LO];
    wire [1:0] new_cdm = shift_in[`SCR_CDM_HI:`SCR_CDM_LO];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_step       <= 1'b0;
            phase_step_value <= 12'h000;
            sync_reset       <= 1'b0;
        end else begin
            // Only the entry into phase mode counts; host must first write a code other than 10
            phase_step <= wr3 && locked &&
                          (new_cdm == `SCR_CDM_PHASE) &&
                          (old_cdm != `SCR_CDM_PHASE);
            if (wr3 && locked && (new_cdm == `SCR_CDM_PHASE))
                phase_step_value <= regs[1][`SCR_PHASE_HI:`SCR_PHASE_LO];
            sync_reset <= (pin_fn == `SCR_MUX_SYNC) && mux_rise;
        end
    end

    // ======================================================================
    // Converter sequence
    reg         adc_busy;
    reg  [2:0]  adc_src;
    reg  [2:0]  adc_step;
    reg  [13:0] adc_time;
    reg  [6:0]  adc_result;
    wire        adc_tick;
    wire        adc_done;
    wire [2:0]  new_src  = shift_in[`SCR_CONVERTER_SOURCE_SELECT_HI:`SCR_CONVERTER_SOURCE_SELECT_LO];
    wire        start_up = wr5 && shift_in[`SCR_CONVERTER_START_BIT] &&
                           !regs[5][`SCR_CONVERTER_START_BIT];
    wire        src_ok   = (new_src == `SCR_SRC_TUNE) ||
                           (new_src == `SCR_SRC_TEMP);

    scr_tick_div #(.WIDTH(12)) u_adc_div (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .enable  (adc_busy),
        .divisor (regs[3][`SCR_CLOCK_DIVIDER_VALUE_HI:`SCR_CLOCK_DIVIDER_VALUE_LO]),
        .tick    (adc_tick)
    );

    // Hard cap keeps the bound even with a badly chosen divider
    assign adc_done = (adc_tick && adc_step == `SCR_ADC_STEPS - 1'b1) ||
                      (adc_time >= CONV_LIMIT - 1'b1);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_busy   <= 1'b0;
            adc_src    <= 3'h0;
            adc_step   <= 3'h0;
            adc_time   <= 14'h0000;
            adc_result <= 7'h00;
        end else if (start_up && src_ok) begin
            adc_busy <= 1'b1;
            adc_src  <= new_src;
            adc_step <= 3'h0;
            adc_time <= 14'h0000;
        end else if (adc_busy) begin
            adc_time <= adc_time + 1'b1;
            if (adc_tick)
                adc_step <= adc_step + 1'b1;
            if (adc_done) begin
                adc_busy   <= 1'b0;
                adc_result <= (adc_src == `SCR_SRC_TUNE) ?
                              tune_s : temp_s;
            end
        end
    end

    // ======================================================================
    // Multipurpose pin output and readback shifter
    reg [31:0] rb_shift;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_shift <= 32'h00000000;
            mux_out  <= 1'b0;
            mux_oe   <= 1'b0;
        end else begin
            if (le_rise && pin_fn == `SCR_MUX_READ)
                rb_shift <= {9'h000, adc_result, 13'h0000,
                             `SCR_ADDR_READBACK};
            else if (sclk_rise)
                rb_shift <= {rb_shift[30:0], 1'b0};
            case (pin_fn)
                `SCR_MUX_HIGH: begin
                    mux_out <= 1'b1;
                    mux_oe  <= 1'b1;
                end
                `SCR_MUX_LOW: begin
                    mux_out <= 1'b0;
                    mux_oe  <= 1'b1;
                end
                `SCR_MUX_DLOCK: begin
                    mux_out <= locked;
                    mux_oe  <= 1'b1;
                end
                `SCR_MUX_READ: begin
                    mux_out <= rb_shift[31];
                    mux_oe  <= 1'b1;
                end
                default: begin
                    // Sync input, high impedance and reserved codes
                    mux_out <= 1'b0;
                    mux_oe  <= 1'b0;
                end
            endcase
        end
    end
endmodule // scr_control_bank

// File: verif/scr_chk_assertions.sv
// Port-level assertions for the serial control bank
`timescale 1ns/1ps
module scr_chk (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        mux_oe,
    input wire        integer_mode,
    input wire [15:0] int_value,
    input wire [1:0]  noise_mode,
    input wire        autoselect_busy,
    input wire        phase_step,
    input wire        sync_reset,
    input wire        range_error
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ========
    // Sequencing, noise code and range flag
    a_busy_min: assert property ($rose(autoselect_busy) |->
        autoselect_busy[*8]) else $error("busy too short");
    a_busy_max: assert property ($rose(autoselect_busy) |->
        ##[1:1000] !autoselect_busy) else $error("busy too long");
    a_phase_pulse: assert property (phase_step |=> !phase_step)
        else $error("phase pulse too long");
    a_phase_locked: assert property (phase_step |-> !autoselect_busy)
        else $error("phase step while unlocked");
    a_sync_pulse: assert property (sync_reset |=> !sync_reset)
        else $error("sync pulse too long");
    a_sync_input: assert property (sync_reset |-> !mux_oe)
        else $error("sync while pin driven");
    a_noise_code: assert property (noise_mode != 2'h1)
        else $error("reserved noise mode");
    // Settled check tolerates a one-cycle lag on the flag
    a_range_flag: assert property ($stable(int_value) && (
        integer_mode ? int_value < 16'h0010 : int_value < 16'h0013 ||
        int_value > 16'h0FFB) |-> range_error) else $error("range missed");
    c_phase: cover property (phase_step);
    c_sync: cover property (sync_reset);
    c_select: cover property ($fell(autoselect_busy));
endmodule // scr_chk

// File: verif/scr_host.sv
// Host model shifting words over the three-wire link
`timescale 1ns/1ps
module scr_host (
    input  wire  sys_clk,
    input  wire  mux_pin,
    output logic ser_clk = 0,
    output logic ser_data = 0,
    output logic ser_le = 0
);
    // ========
    // Word transfer, MSB first; pin level taken before each rise
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            ser_data = w[i];
            repeat (4) @(negedge sys_clk);
            r[i] = mux_pin;
            ser_clk = 1;
            repeat (4) @(negedge sys_clk);
            ser_clk = 0;
        end
        ser_le = 1;
        repeat (8) @(negedge sys_clk);
        ser_le = 0;
        // Idle data toggles so no stale bit looks valid
        ser_data = ~w[0];
        repeat (4) @(negedge sys_clk);
    endtask
endmodule // scr_host

// File: verif/tb_top.sv
// Self-checking bench for the serial control bank
`timescale 1ns/1ps
module tb_top;
    localparam BS = 4;
    localparam TC = 300;
    // ========
    // Clock, pins and counters
    logic        sys_clk = 0;
    logic        rst_n = 0;
    logic        mux_drv = 0;
    logic [6:0]  tune_level = 7'h55;
    logic [6:0]  temp_level = 7'h2B;
    logic        tune_above = 1'b1;
    logic [31:0] r;
    int          n_errors = 0, n_checks = 0, cycles = 0;
    int          busy_len = 0, n_phase = 0, n_sync = 0;
    wire         ser_clk, ser_data, ser_le, mux_out, mux_oe, mux_pin;
    wire         integer_mode, autoselect_busy, phase_step, sync_reset;
    wire         range_error;
    wire [15:0]  int_value;
    wire [11:0]  frac_value, modulus, phase_step_value;
    wire [9:0]   ref_div;
    wire [5:0]   osc_select;
    wire [3:0]   pump_current;
    wire [1:0]   pump_linearity, pump_test_mode, noise_mode;
    // Device drive wins over the bench level
    assign mux_pin = mux_oe ? mux_out : mux_drv;
    always #4 sys_clk = ~sys_clk;
    scr_host host (.sys_clk(sys_clk), .mux_pin(mux_pin), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_le(ser_le));
    scr_control_bank #(.CONV_CYCLES(200), .TEMP_CYCLES(TC)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_le(ser_le), .mux_in(mux_pin),
        .mux_out(mux_out), .mux_oe(mux_oe), .tune_above_mid(tune_above),
        .tune_level(tune_level), .temp_level(temp_level),
        .integer_mode(integer_mode), .int_value(int_value),
        .frac_value(frac_value), .modulus(modulus), .ref_div(ref_div),
        .pump_current(pump_current), .pump_linearity(pump_linearity),
        .pump_test_mode(pump_test_mode), .noise_mode(noise_mode),
        .osc_select(osc_select), .autoselect_busy(autoselect_busy),
        .phase_step(phase_step), .phase_step_value(phase_step_value),
        .sync_reset(sync_reset), .range_error(range_error));
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (autoselect_busy === 1'b1) busy_len <= busy_len + 1;
        if (phase_step === 1'b1) n_phase <= n_phase + 1;
        if (sync_reset === 1'b1) n_sync <= n_sync + 1;
        if (cycles == 40000) begin
            n_errors++;
            summarize();
        end
    end
    // ========
    // Tasks
    task chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [31:0] w);
        host.xfer(w, r);
        repeat (4) @(negedge sys_clk);
    endtask
    task autosel(input logic [31:0] r3, input int lo, input int hi);
        wr(r3);
        busy_len = 0;
        wr(32'h00320038);
        for (int k = 0; k < 3000 && autoselect_busy !== 1'b0; k++)
            @(negedge sys_clk);
        chk(busy_len >= lo && busy_len <= hi, 1);
    endtask
    task summarize;
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ========
    // Main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1;
        repeat (3) @(negedge sys_clk);
        chk({int_value, modulus, ref_div}, {16'h00FA, 12'hFFF, 10'h001});
        wr(32'h6000401C);
        wr(32'h48918029);
        chk({pump_linearity, pump_test_mode, modulus}, {4'h9, 12'hFFF});
        autosel(32'h0000000B, 10 * BS, 10 * BS + 2);
        chk({int_value, frac_value, modulus}, 40'h0064007005);
        chk(osc_select, 6'h3F);
        wr(32'h60400005);
        tune_above = 1'b0;
        autosel(32'h0100000B, 10 * BS + TC, 10 * BS + TC + 2);
        chk(osc_select, 6'h00);
        wr(32'h0001000B);
        chk({n_phase[3:0], phase_step_value}, {4'h1, 12'h123});
        wr(32'hAA00000B);
        busy_len = 0;
        wr(32'h80050000);
        chk({osc_select, range_error, integer_mode}, {6'h2A, 2'h3});
        chk(busy_len, 0);
        wr(32'h80080000);
        chk(range_error, 1'b0);
        wr(32'hFFFFFFFF);
        chk(int_value, 16'h0010);
        for (int i = 0; i < 4; i++) begin
            wr({1'b0, 2'(i), 29'h00004242});
            chk(noise_mode, i == 1 ? 2'h0 : 2'(i));
        end
        chk(pump_current, 4'h0);
        wr(32'h80080000);
        chk(pump_current, 4'h1);
        wr(32'h10004042);
        wr(32'h00000023);
        for (int i = 0; i < 2; i++) begin
            wr(i ? 32'h0044004D : 32'h00440065);
            repeat (250) @(negedge sys_clk);
            host.xfer(32'h00000006, r);
            host.xfer(32'h00000006, r);
            chk(r, {9'h0, i ? temp_level : tune_level, 13'h0, 3'h6});
            wr(32'h00440005);
        end
        wr(32'h1C004042);
        wr(32'h00400005);
        chk(mux_oe, 1'b0);
        mux_drv = 1;
        repeat (8) @(negedge sys_clk);
        chk(n_sync, 1);
        mux_drv = 0;
        wr(32'h00004042);
        chk(mux_oe, 1'b0);
        wr(32'h18004042);
        chk({mux_oe, mux_out}, 2'h3);
        summarize();
    end
endmodule // tb_top

bind scr_control_bank scr_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .mux_oe(mux_oe), .integer_mode(integer_mode), .int_value(int_value),
    .noise_mode(noise_mode), .autoselect_busy(autoselect_busy),
    .phase_step(phase_step), .sync_reset(sync_reset),
    .range_error(range_error));
